/* logic/qfl_pkg.sv */
// Operation
// - Quad-output read: opcode, 24 address bits, 8 dummy clocks on line 0.
// - Quad-output read data: four bits per falling edge, MSB on line 3.
// - Both quad reads increment the address per byte and wrap to zero.
// - Reads run while chip select is low; raising it stops driving.
// - Quad reads arriving during a busy cycle are ignored entirely.
// - Quad I/O read: address and mode four bits per rising edge.
// - Mode byte follows address, upper nibble A; four dummy clocks follow.
// - After mode A, next read skips the opcode until a mode byte without upper nibble A or a mode reset.
// - Mode reset clears mode bits, ending continuous quad I/O reads.
// - Single-line page write: opcode, 24-bit address, 1 to 256 bytes.
// - Page write into a block-protected page is ignored.
// - Quad page write needs quad enable and latch; single needs latch.
// - Programming starts only on chip select rising after whole bytes.
// - While programming, every command of this block is ignored.
// - Write-in-progress reads 1 during programming, 0 when done.
// - Over 256 bytes wrap in page; only the last 256 kept.
// - Start anywhere in page, wrap to page start; unsent bytes unchanged.
// - Programming only turns ones into zeros.
// - Quad page write opcode 00110010b; address and data on four lines.
// - Write-enable latch clears when programming completes.
package qfl_pkg;
   localparam logic [7:0] OP_QUAD_PAGE_WRITE = 8'h32;
   localparam logic [7:0] OP_CONT_EXIT = 8'hFF;
   localparam logic [3:0] CONT_MODE_NIB = 4'hA;
   localparam logic [5:0] ADDR_BITS = 6'h18;
   localparam logic [5:0] MODE_NIBS = 6'h02;
   localparam logic [5:0] DUMMY_CLKS_QO = 6'h08;
   localparam logic [5:0] DUMMY_CLKS_QIO = 6'h04;
   localparam logic [5:0] BYTE_BITS = 6'h08;
   localparam logic [5:0] OP_BITS = 6'h08;
   localparam int PAGE_BYTES = 256;
   localparam int BLOCK_SHIFT = 16;
   localparam int CLK_PERIOD_NS = 25;
   localparam int PROG_TIME_NS = 100000;
   localparam int PROG_CYC = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] LINE_RST = 4'h0;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [5:0] PINS_IDLE = 6'h20;

   typedef struct packed {
      logic cs_n;
      logic sck;
      logic [3:0] io;
   } qfl_pins_t;

   typedef enum logic [1:0] {
      CMD_READ_QO = 2'h0,
      CMD_READ_QIO = 2'h1,
      CMD_WRITE_1 = 2'h2,
      CMD_WRITE_4 = 2'h3
   } qfl_cmd_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_CMD = 3'b001,
      ST_ADDR = 3'b011,
      ST_MODE = 3'b010,
      ST_DUMMY = 3'b110,
      ST_RD = 3'b111,
      ST_WR = 3'b101,
      ST_IGN = 3'b100
   } qfl_state_t;
endpackage

/* logic/qfl_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module qfl_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] d_out
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         meta_r <= RST_VAL;
         d_out <= RST_VAL;
      end else begin
         meta_r <= d_in;
         d_out <= meta_r;
      end
   end
endmodule // qfl_sync
`default_nettype wire

/* logic/qfl_dev.sv */
`timescale 1ns/1ps
`default_nettype none
module qfl_dev #(
   parameter int ADDR_W = 20,
   parameter logic [7:0] OP_READ_QUAD_OUT = 8'h6B,
   parameter logic [7:0] OP_READ_QUAD_IO = 8'hEB,
   parameter logic [7:0] OP_PAGE_WRITE_1 = 8'h02,
   parameter int PROG_CYC = qfl_pkg::PROG_CYC
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire qfl_pkg::qfl_pins_t pins,
   output logic [3:0] quad_line_o,
   output logic [3:0] quad_line_oe,
   input wire logic write_enable_latch,
   input wire logic quad_enable_bit,
   input wire logic [3:0] protect_bits,
   input wire logic other_busy,
   output logic write_in_progress,
   output logic wel_clear
);
   localparam int PG_W = ADDR_W - 8;

   qfl_pkg::qfl_pins_t pins_s;
   qfl_pkg::qfl_state_t state_r;
   qfl_pkg::qfl_cmd_t kind_r;
   logic sck_d_r, cs_d_r;
   logic sck_rise, sck_fall, cs_rise, cs_fall;
   logic quad_r, hi_r, cont_r, got_byte_r;
   logic [5:0] cnt_r;
   logic [5:0] step;
   logic [23:0] sh_r, sh_nxt;
   logic [ADDR_W-1:0] addr_r;
   logic [7:0] mem [0:(1<<ADDR_W)-1] = '{default: qfl_pkg::ERASED_BYTE};
   logic [7:0] pbuf [0:qfl_pkg::PAGE_BYTES-1];
   logic [qfl_pkg::PAGE_BYTES-1:0] pval_r;
   logic [7:0] rd_byte, op_byte;
   logic wr_byte_done, page_prot, busy, prog_ok;
   logic prog_busy_r;
   logic [8:0] prog_idx_r;
   logic [15:0] prog_cnt_r;
   logic [PG_W-1:0] page_r;

   qfl_sync #(.W(6), .RST_VAL(qfl_pkg::PINS_IDLE)) u_sync (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .d_in(pins),
      .d_out(pins_s)
   );

   function automatic logic prot_hit(input logic [ADDR_W-1:0] a,
                                     input logic [3:0] bp);
      logic hit;
      int sh;
      hit = 1'b0;
      sh = 0;
      if (bp != 4'h0) begin
         sh = qfl_pkg::BLOCK_SHIFT + int'(bp) - 1;
         hit = 1'b1;
         for (int i = 0; i < ADDR_W; i++) begin
            if (i >= sh && !a[i]) begin
               hit = 1'b0;
            end
         end
      end
      return hit;
   endfunction

   // Edge detection on synchronised pins
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sck_d_r <= 1'b0;
         cs_d_r <= 1'b1;
      end else begin
         sck_d_r <= pins_s.sck;
         cs_d_r <= pins_s.cs_n;
      end
   end

   assign sck_rise = pins_s.sck & ~sck_d_r;
   assign sck_fall = ~pins_s.sck & sck_d_r;
   assign cs_rise = pins_s.cs_n & ~cs_d_r;
   assign cs_fall = ~pins_s.cs_n & cs_d_r;
   assign busy = prog_busy_r | other_busy;
   assign step = quad_r ? 6'h04 : 6'h01;
   assign sh_nxt = quad_r ? {sh_r[19:0], pins_s.io}
                          : {sh_r[22:0], pins_s.io[0]};
   assign op_byte = sh_nxt[7:0];
   assign rd_byte = mem[addr_r];
   assign wr_byte_done = (state_r == qfl_pkg::ST_WR) && sck_rise &&
                         (cnt_r + step == qfl_pkg::BYTE_BITS);
   assign page_prot = prot_hit(addr_r, protect_bits);
   assign prog_ok = cs_rise && state_r == qfl_pkg::ST_WR && got_byte_r &&
                    cnt_r == 6'h00 && write_enable_latch && !page_prot &&
                    (kind_r != qfl_pkg::CMD_WRITE_4 || quad_enable_bit) &&
                    !busy;

   // Command sequencer
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= qfl_pkg::ST_IDLE;
         kind_r <= qfl_pkg::CMD_READ_QO;
         quad_r <= 1'b0;
         hi_r <= 1'b0;
         cont_r <= 1'b0;
         got_byte_r <= 1'b0;
         cnt_r <= 6'h00;
         sh_r <= 24'h00_0000;
         addr_r <= '0;
         quad_line_o <= qfl_pkg::LINE_RST;
      end else if (pins_s.cs_n) begin
         state_r <= qfl_pkg::ST_IDLE;
      end else if (cs_fall) begin
         cnt_r <= 6'h00;
         got_byte_r <= 1'b0;
         hi_r <= 1'b0;
         if (busy) begin
            state_r <= qfl_pkg::ST_IGN;
         end else if (cont_r) begin
            state_r <= qfl_pkg::ST_ADDR;
            kind_r <= qfl_pkg::CMD_READ_QIO;
            quad_r <= 1'b1;
         end else begin
            state_r <= qfl_pkg::ST_CMD;
            quad_r <= 1'b0;
         end
      end else begin
         case (state_r)
            qfl_pkg::ST_CMD: begin
               if (sck_rise) begin
                  sh_r <= sh_nxt;
                  cnt_r <= cnt_r + 6'h01;
                  if (cnt_r == qfl_pkg::OP_BITS - 6'h01) begin
                     cnt_r <= 6'h00;
                     state_r <= qfl_pkg::ST_ADDR;
                     if (op_byte == OP_READ_QUAD_OUT) begin
                        kind_r <= qfl_pkg::CMD_READ_QO;
                     end else if (op_byte == OP_READ_QUAD_IO) begin
                        kind_r <= qfl_pkg::CMD_READ_QIO;
                        quad_r <= 1'b1;
                     end else if (op_byte == OP_PAGE_WRITE_1) begin
                        kind_r <= qfl_pkg::CMD_WRITE_1;
                     end else if (op_byte == qfl_pkg::OP_QUAD_PAGE_WRITE &&
                                  quad_enable_bit) begin
                        kind_r <= qfl_pkg::CMD_WRITE_4;
                        quad_r <= 1'b1;
                     end else begin
                        state_r <= qfl_pkg::ST_IGN;
                        if (op_byte == qfl_pkg::OP_CONT_EXIT) begin
                           cont_r <= 1'b0;
                        end
                     end
                  end
               end
            end
            qfl_pkg::ST_ADDR: begin
               if (sck_rise) begin
                  sh_r <= sh_nxt;
                  cnt_r <= cnt_r + step;
                  if (cnt_r + step == qfl_pkg::ADDR_BITS) begin
                     cnt_r <= 6'h00;
                     addr_r <= sh_nxt[ADDR_W-1:0];
                     case (kind_r)
                        qfl_pkg::CMD_READ_QO: state_r <= qfl_pkg::ST_DUMMY;
                        qfl_pkg::CMD_READ_QIO: state_r <= qfl_pkg::ST_MODE;
                        default: state_r <= qfl_pkg::ST_WR;
                     endcase
                  end
               end
            end
            qfl_pkg::ST_MODE: begin
               if (sck_rise) begin
                  sh_r <= sh_nxt;
                  cnt_r <= cnt_r + 6'h01;
                  if (cnt_r == qfl_pkg::MODE_NIBS - 6'h01) begin
                     cnt_r <= 6'h00;
                     state_r <= qfl_pkg::ST_DUMMY;
                     cont_r <= (sh_r[3:0] == qfl_pkg::CONT_MODE_NIB);
                  end
               end
            end
            qfl_pkg::ST_DUMMY: begin
               if (sck_rise) begin
                  cnt_r <= cnt_r + 6'h01;
                  if ((kind_r == qfl_pkg::CMD_READ_QO &&
                       cnt_r == qfl_pkg::DUMMY_CLKS_QO - 6'h01) ||
                      (kind_r == qfl_pkg::CMD_READ_QIO &&
                       cnt_r == qfl_pkg::DUMMY_CLKS_QIO - 6'h01)) begin
                     cnt_r <= 6'h00;
                     state_r <= qfl_pkg::ST_RD;
                     hi_r <= 1'b0;
                  end
               end
            end
            qfl_pkg::ST_RD: begin
               if (sck_fall) begin
                  hi_r <= ~hi_r;
                  if (!hi_r) begin
                     quad_line_o <= rd_byte[7:4];
                  end else begin
                     quad_line_o <= rd_byte[3:0];
                     addr_r <= addr_r + 1'b1;
                  end
               end
            end
            qfl_pkg::ST_WR: begin
               if (sck_rise) begin
                  sh_r <= sh_nxt;
                  cnt_r <= cnt_r + step;
                  if (wr_byte_done) begin
                     cnt_r <= 6'h00;
                     got_byte_r <= 1'b1;
                     addr_r[7:0] <= addr_r[7:0] + 8'h01;
                  end
               end
            end
            default: state_r <= state_r;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         quad_line_oe <= qfl_pkg::LINE_RST;
      end else begin
         quad_line_oe <= (state_r == qfl_pkg::ST_RD && !pins_s.cs_n) ?
                         4'hF : qfl_pkg::LINE_RST;
      end
   end

   // Page buffer: last byte written at each offset wins
   always_ff @(posedge clk_sys) begin
      if (wr_byte_done) begin
         pbuf[addr_r[7:0]] <= op_byte;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pval_r <= '0;
      end else if (cs_fall && !busy) begin
         pval_r <= '0;
      end else if (wr_byte_done) begin
         pval_r[addr_r[7:0]] <= 1'b1;
      end
   end

   // Self-timed program engine
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         prog_busy_r <= 1'b0;
         prog_idx_r <= 9'h000;
         prog_cnt_r <= 16'h0000;
         page_r <= '0;
         wel_clear <= 1'b0;
      end else begin
         wel_clear <= 1'b0;
         if (prog_ok) begin
            prog_busy_r <= 1'b1;
            prog_idx_r <= 9'h000;
            prog_cnt_r <= 16'(PROG_CYC - 1);
            page_r <= addr_r[ADDR_W-1:8];
         end else if (prog_busy_r) begin
            if (!prog_idx_r[8]) begin
               prog_idx_r <= prog_idx_r + 9'h001;
            end
            prog_cnt_r <= prog_cnt_r - 16'h0001;
            if (prog_cnt_r == 16'h0000) begin
               prog_busy_r <= 1'b0;
               wel_clear <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (prog_busy_r && !prog_idx_r[8] && pval_r[prog_idx_r[7:0]]) begin
         mem[{page_r, prog_idx_r[7:0]}] <=
            mem[{page_r, prog_idx_r[7:0]}] & pbuf[prog_idx_r[7:0]];
      end
   end

   assign write_in_progress = prog_busy_r;

   sequence s_prog_start;
      $rose(write_in_progress);
   endsequence

   sequence s_prog_end;
      $fell(write_in_progress);
   endsequence

   a_start_on_cs: assert property (@(posedge clk_sys) disable iff (!reset_n)
      s_prog_start |-> $past(cs_rise) && $past(got_byte_r))
      else $error("Program started without chip select rising");
   a_start_needs_wel: assert property (@(posedge clk_sys) disable iff (!reset_n)
      s_prog_start |-> $past(write_enable_latch) &&
      (kind_r != qfl_pkg::CMD_WRITE_4 || $past(quad_enable_bit)))
      else $error("Program started without enable preconditions");
   a_start_unprot: assert property (@(posedge clk_sys) disable iff (!reset_n)
      s_prog_start |-> !$past(page_prot))
      else $error("Program started on protected page");
   a_wip_holds: assert property (@(posedge clk_sys) disable iff (!reset_n)
      s_prog_start |-> write_in_progress [*8])
      else $error("Write in progress dropped early");
   a_wel_clear_end: assert property (@(posedge clk_sys) disable iff (!reset_n)
      s_prog_end |-> wel_clear ##1 !wel_clear)
      else $error("Latch clear pulse missing at program end");
   a_busy_ignore: assert property (@(posedge clk_sys) disable iff (!reset_n)
      cs_fall && busy |=> state_r == qfl_pkg::ST_IGN)
      else $error("Command taken while busy");
   a_release_lines: assert property (@(posedge clk_sys) disable iff (!reset_n)
      cs_rise |=> quad_line_oe == 4'h0)
      else $error("Lines still driven after chip select rose");
   a_read_incr: assert property (@(posedge clk_sys) disable iff (!reset_n)
      state_r == qfl_pkg::ST_RD && sck_fall && hi_r && !pins_s.cs_n
      |=> addr_r == $past(addr_r) + 1'b1)
      else $error("Read address did not advance");
   a_nibble_high: assert property (@(posedge clk_sys) disable iff (!reset_n)
      state_r == qfl_pkg::ST_RD && sck_fall && !hi_r && !pins_s.cs_n
      |=> quad_line_o == $past(rd_byte[7:4]))
      else $error("High nibble not driven first");
   a_page_wrap: assert property (@(posedge clk_sys) disable iff (!reset_n)
      wr_byte_done && !pins_s.cs_n
      |=> addr_r[7:0] == $past(addr_r[7:0]) + 8'h01 &&
      addr_r[ADDR_W-1:8] == $past(addr_r[ADDR_W-1:8]))
      else $error("Page write address left its page");
   a_cont_skip: assert property (@(posedge clk_sys) disable iff (!reset_n)
      cs_fall && cont_r && !busy |=> state_r == qfl_pkg::ST_ADDR && quad_r)
      else $error("Continuous read did not skip opcode");
endmodule // qfl_dev
`default_nettype wire

/* verif/qfl_host.sv */
`timescale 1ns/1ps
`default_nettype none
module qfl_host #(
   parameter logic [7:0] OP_QO = 8'h00,
   parameter logic [7:0] OP_QIO = 8'h00,
   parameter logic [7:0] OP_W1 = 8'h00
) (
   input wire logic clk_sys,
   input wire logic [3:0] quad_line_o,
   input wire logic [3:0] quad_line_oe,
   output var qfl_pkg::qfl_pins_t pins,
   output logic rd_stb,
   output logic [7:0] rd_byte,
   output logic [3:0] rd_oe
);
   logic cs_n = 1'b1;
   logic sck = 1'b0;
   logic [3:0] h_io = 4'h0;
   logic [3:0] io_w;
   // Wire level: device where it drives, host elsewhere
   assign io_w = (quad_line_oe & quad_line_o) | (~quad_line_oe & h_io);
   assign pins = {cs_n, sck, io_w};
   initial begin
      rd_stb = 1'b0;
      rd_byte = 8'h00;
      rd_oe = 4'h0;
   end
   task automatic half();
      repeat (4) @(posedge clk_sys);
      #1;
   endtask
   // One serial clock, lines set while clock is low
   task automatic clk_out(input logic [3:0] v);
      h_io = v;
      half();
      sck = 1'b1;
      half();
      sck = 1'b0;
   endtask
   task automatic ser8(input logic [7:0] v);
      for (int i = 7; i >= 0; i--) begin
         clk_out({~h_io[3:1], v[i]});
      end
   endtask
   task automatic nib8(input logic [7:0] v);
      clk_out(v[7:4]);
      clk_out(v[3:0]);
   endtask
   task automatic addr1(input logic [23:0] a);
      ser8(a[23:16]);
      ser8(a[15:8]);
      ser8(a[7:0]);
   endtask
   task automatic addr4(input logic [23:0] a);
      nib8(a[23:16]);
      nib8(a[15:8]);
      nib8(a[7:0]);
   endtask
   // Released lines toggle so stale values never read back
   task automatic rx_byte();
      for (int k = 0; k < 2; k++) begin
         h_io = ~h_io;
         half();
         rd_byte = {rd_byte[3:0], io_w};
         sck = 1'b1;
         half();
         sck = 1'b0;
      end
      rd_oe = quad_line_oe;
      rd_stb = 1'b1;
      #1 rd_stb = 1'b0;
   endtask
   task automatic start();
      half();
      cs_n = 1'b0;
   endtask
   task automatic stop();
      cs_n = 1'b1;
      half();
      half();
   endtask
   task automatic read_qo(input logic [23:0] a, input int n);
      start();
      ser8(OP_QO);
      addr1(a);
      repeat (8) clk_out(~h_io);
      repeat (n) rx_byte();
      stop();
   endtask
   task automatic read_qio(input logic cont, input logic [23:0] a,
         input logic [7:0] mode, input int n);
      start();
      if (!cont) ser8(OP_QIO);
      addr4(a);
      nib8(mode);
      repeat (4) clk_out(~h_io);
      repeat (n) rx_byte();
      stop();
   endtask
   task automatic write(input logic quad, input logic [23:0] a,
         input logic [7:0] d [$], input logic cut);
      start();
      ser8(quad ? qfl_pkg::OP_QUAD_PAGE_WRITE : OP_W1);
      if (quad) addr4(a);
      else addr1(a);
      foreach (d[i]) begin
         if (quad) nib8(d[i]);
         else ser8(d[i]);
      end
      if (cut) clk_out(4'h0);
      stop();
   endtask
   task automatic mode_reset();
      start();
      repeat (8) clk_out(4'hF);
      stop();
   endtask
endmodule // qfl_host
`default_nettype wire

/* verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int AW = 12;
   localparam int PC = 1000;
   localparam int MSZ = 1 << AW;
   localparam logic [7:0] OPQ = 8'h6B;
   localparam logic [7:0] OPI = 8'hEB;
   localparam logic [7:0] OPW = 8'h02;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic we_latch = 1'b0;
   logic quad_en = 1'b0;
   logic oth_busy = 1'b0;
   logic [3:0] prot = 4'h0;
   qfl_pkg::qfl_pins_t pins;
   logic [3:0] q_o, q_oe, rd_oe;
   logic prog_busy, wclr, rd_stb;
   logic [7:0] rd_byte;
   logic [7:0] mem [MSZ];
   logic [11:0] exp_q [$];
   int prog_q [$];
   int err_count = 0;
   int checks_done = 0;
   int busy_cnt = 0;
   int prog_exp;

   always #12.5 clk_sys = ~clk_sys;

   qfl_dev #(.ADDR_W(AW), .OP_READ_QUAD_OUT(OPQ), .OP_READ_QUAD_IO(OPI),
      .OP_PAGE_WRITE_1(OPW), .PROG_CYC(PC)) uut (.clk_sys(clk_sys),
      .reset_n(reset_n), .pins(pins), .quad_line_o(q_o),
      .quad_line_oe(q_oe), .write_enable_latch(we_latch),
      .quad_enable_bit(quad_en), .protect_bits(prot),
      .other_busy(oth_busy), .write_in_progress(prog_busy),
      .wel_clear(wclr));
   qfl_host #(.OP_QO(OPQ), .OP_QIO(OPI), .OP_W1(OPW)) host (
      .clk_sys(clk_sys), .quad_line_o(q_o), .quad_line_oe(q_oe),
      .pins(pins), .rd_stb(rd_stb), .rd_byte(rd_byte), .rd_oe(rd_oe));

   task automatic report(input bit bad, input string w,
         input logic [31:0] e, input logic [31:0] s);
      checks_done++;
      if (bad) begin
         err_count++;
         $display("MISMATCH %s expected %0h seen %0h", w, e, s);
      end
   endtask
   task automatic cmp_byte(input string w, input logic [7:0] e,
         input logic [7:0] s);
      report(s !== e, w, {24'h00_0000, e}, {24'h00_0000, s});
   endtask
   task automatic cmp_nib(input string w, input logic [3:0] e,
         input logic [3:0] s);
      report(s !== e, w, {28'h000_0000, e}, {28'h000_0000, s});
   endtask
   task automatic cmp_int(input string w, input int e, input int s);
      report(s != e, w, e, s);
   endtask
   task automatic tally_and_finish();
      if (exp_q.size() != 0 || prog_q.size() != 0) err_count++;
      $display("Checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Read monitor: oldest note against each byte the host takes in
   always @(posedge rd_stb) begin
      logic [11:0] e;
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 12'hxxx;
      cmp_nib("line enable", e[11:8], rd_oe);
      if (e[11:8] !== 4'h0) begin
         cmp_byte("read byte", e[7:0], rd_byte);
      end
   end
   // Program monitor: busy length, and the outside latch clears
   always @(posedge clk_sys) begin
      if (prog_busy === 1'b1) busy_cnt <= busy_cnt + 1;
      if (wclr === 1'b1) begin
         we_latch <= 1'b0;
         busy_cnt <= 0;
         prog_exp = (prog_q.size() > 0) ? prog_q.pop_front() : -1;
         cmp_int("program cycles", prog_exp, busy_cnt);
      end
   end
   initial begin
      repeat (100000) @(posedge clk_sys);
      err_count++;
      tally_and_finish();
   end

   task automatic expect_rd(input logic [23:0] a, input int n, input logic on);
      for (int i = 0; i < n; i++) begin
         exp_q.push_back(on ? {4'hF, mem[(int'(a) + i) % MSZ]} : 12'h000);
      end
   endtask
   task automatic wait_idle(input logic ok);
      int k;
      k = 0;
      cmp_nib("program start", 4'(ok), 4'(prog_busy));
      while (prog_busy !== 1'b0 && k < PC + 50) begin
         @(posedge clk_sys);
         k++;
      end
      if (k >= PC + 50) begin
         err_count++;
         tally_and_finish();
      end
      repeat (4) @(posedge clk_sys);
      #1;
   endtask
   task automatic prog(input logic quad, input logic [23:0] a, input int n,
         input logic cut, input logic ok, input logic probe);
      logic [7:0] d [$];
      logic [7:0] pg [256];
      int base;
      base = (int'(a) % MSZ) - int'(a[7:0]);
      foreach (pg[i]) pg[i] = 8'hFF;
      for (int i = 0; i < n; i++) begin
         d.push_back(8'($urandom));
         pg[(int'(a[7:0]) + i) % 256] = d[i];
      end
      if (ok) begin
         prog_q.push_back(PC);
         foreach (pg[i]) mem[base + i] &= pg[i];
      end
      host.write(quad, a, d, cut);
      if (probe) begin
         expect_rd(a, 1, 1'b0);
         host.read_qo(a, 1);
      end
      wait_idle(ok);
   endtask

   initial begin
      void'($urandom(32'h0000_97f6));
      foreach (mem[i]) mem[i] = qfl_pkg::ERASED_BYTE;
      repeat (4) @(posedge clk_sys);
      #1 reset_n = 1'b1;
      cmp_nib("enables after reset", 4'h0, q_oe);
      cmp_nib("busy after reset", 4'h0, {3'b000, prog_busy});
      host.mode_reset();
      for (int i = 0; i < 4; i++) begin
         we_latch = (i != 0);
         prot = (i == 2) ? 4'h1 : 4'h0;
         prog(i == 1, 24'h00_0040, 2, i == 3, '0, '0);
      end
      prot = 4'h0;
      we_latch = 1'b1;
      prog('0, 24'h00_0FFE, 4, '0, '1, '1);
      we_latch = 1'b1;
      quad_en = 1'b1;
      prog('1, 24'h00_00F0, 258, '0, '1, '0);
      we_latch = 1'b1;
      prog(1'b0, 24'h00_00F0, 2, 1'b0, 1'b1, 1'b0);
      oth_busy = 1'b1;
      expect_rd(24'h00_0000, 1, 1'b0);
      host.read_qo(24'h00_0000, 1);
      oth_busy = 1'b0;
      expect_rd(24'hFF_FFFE, 4, 1'b1);
      host.read_qo(24'hFF_FFFE, 4);
      expect_rd(24'h00_0F00, 3, 1'b1);
      host.read_qio(1'b0, 24'h00_0F00, 8'hA5, 3);
      expect_rd(24'h00_00FE, 2, 1'b1);
      host.read_qio(1'b1, 24'h00_00FE, 8'h30, 2);
      expect_rd(24'h00_0FFF, 2, 1'b1);
      host.read_qio(1'b0, 24'h00_0FFF, 8'hAF, 2);
      host.mode_reset();
      expect_rd(24'h00_0F01, 1, 1'b1);
      host.read_qo(24'h00_0F01, 1);
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire
